// ==== src/rx_msg_store.sv ====
/*
 * Receive message store: writes accepted frames into an eight-buffer
 * ring in system RAM, tracks write index and user read pointer, and
 * raises not-empty, half-full, full and overflow flags.
 * Assumes frames arrive on a valid/ready port and RAM takes one word
 * per request, acknowledged by a one-cycle mem_ack.
 */
`default_nettype none

// Contract
// - Payload bytes 0..3 in first data word, 4..7 in second, byte 0 lowest.
// - Buffers live in system RAM; plain word writes, no set/clear/invert aliases.
// - Payload-only mode stores payload alone, dropping identifier, reserved bits, length.
// - Payload-only mode enabled by control bit 12.
// - Payload-only mode never writes a time stamp.
// - Payload-only mode writes eight bytes, zeroing bytes beyond received length.
// - User address register returns address of next buffer software should read.
// - Writing bit 13 of control advances user address to next buffer while unread messages remain; ignored when ring empty.
// - After configuration user address and storage start at base address.
// - Write index advances after each stored message; user address waits for software.
// - Not-empty, half-full and full notifications, pollable or as interrupts.
// - Not-empty set when first message enters an empty ring.
// - Half-full set when fourth unread message is stored.
// - Full set when all eight buffers hold unread messages.
// - Message arriving while full is dropped, overflow set, index unchanged.
// - Full format first word: stamp high half, filter code, standard identifier.
// - Stamp field reads zero when capture option is off.

module rx_msg_store (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB register port
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Frames from the protocol receiver
    input  wire logic                   rx_valid,
    input  wire rx_store_pkg::rx_frame_t rx_frame,
    output logic                        rx_ready,
    // Word writes to system RAM
    output logic                        mem_req,
    output rx_store_pkg::mem_word_t     mem_word,
    input  wire logic                   mem_ack,
    // Interrupt
    output logic                        irq
);

    // Buffer start address for a ring index
    function automatic logic [31:0] buf_addr(input logic [31:0] base,
                                             input logic [rx_store_pkg::IDX_W-1:0] idx,
                                             input logic pay_only);
        logic [31:0] stride;
        stride   = pay_only ? rx_store_pkg::STRIDE_PAYLOAD : rx_store_pkg::STRIDE_FULL;
        buf_addr = base + stride * {29'h0, idx};
    endfunction

    // Byte-lane merge of an APB write
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wr,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        merge_strb = res;
    endfunction

    // State
    rx_store_pkg::store_state_t          state_q, state_d;
    rx_store_pkg::rx_frame_t             frame_q;
    logic                                pay_only_q;
    logic [1:0]                          word_q;
    logic [rx_store_pkg::IDX_W-1:0]      wr_idx_q, rd_idx_q;
    logic [3:0]                          count_q, count_d;
    logic [31:0]                         ctrl_q, base_q;
    logic                                stamp_cap_q;
    logic [rx_store_pkg::FLAG_W-1:0]     flags_q, flags_d, mask_q;
    logic [31:0]                         prdata_q;
    logic                                pready_q, pslverr_q;
    logic                                rx_ready_q, mem_req_q, irq_q;
    rx_store_pkg::mem_word_t             mem_word_q;

    // APB access decode
    wire        apb_do    = psel & penable & pready_q;
    wire        apb_wr    = apb_do & pwrite;
    wire        hit_ctrl  = (paddr == rx_store_pkg::OFS_FIFO_CONTROL);
    wire        hit_base  = (paddr == rx_store_pkg::OFS_BASE_ADDRESS);
    wire        hit_ua    = (paddr == rx_store_pkg::OFS_USER_ADDRESS);
    wire        hit_wi    = (paddr == rx_store_pkg::OFS_WRITE_INDEX);
    wire        hit_flag  = (paddr == rx_store_pkg::OFS_INT_FLAGS);
    wire        hit_mask  = (paddr == rx_store_pkg::OFS_INT_MASK);
    wire        hit_mod   = (paddr == rx_store_pkg::OFS_MODULE_CTRL);
    wire        hit_lvl   = (paddr == rx_store_pkg::OFS_LEVEL_STATUS);
    wire        hit_any   = hit_ctrl | hit_base | hit_ua | hit_wi | hit_flag
                          | hit_mask | hit_mod | hit_lvl;
    wire        wr_ctrl   = apb_wr & hit_ctrl;
    wire        wr_base   = apb_wr & hit_base;
    wire [31:0] ctrl_new  = merge_strb(ctrl_q, pwdata, pstrb);
    wire [31:0] mod_new   = merge_strb({31'h0, stamp_cap_q}, pwdata, pstrb);
    wire [31:0] mask_new  = merge_strb({28'h0, mask_q}, pwdata, pstrb);

    // Pointer bump request from software
    wire bump     = wr_ctrl & pstrb[1] & pwdata[rx_store_pkg::POS_PTR_BUMP];
    wire bump_ok  = bump & (count_q != 4'h0);

    // Levels derived from unread count
    wire lvl_ne   = (count_q != 4'h0);
    wire lvl_half = (count_q >= rx_store_pkg::HALF_LEVEL);
    wire lvl_full = (count_q == rx_store_pkg::DEPTH);

    // Frame intake and overflow
    wire accept   = rx_valid & rx_ready_q;
    wire drop     = accept & lvl_full;
    wire take     = accept & ~lvl_full;
    wire commit   = (state_q == rx_store_pkg::ST_COMMIT);
    wire pay_sel  = ctrl_q[rx_store_pkg::POS_PAYLOAD_ONLY];

    // Payload with bytes beyond the received length zeroed
    logic [63:0] pay_masked;
    always_comb
    begin
        pay_masked = frame_q.data;
        for (int b = 0; b < 8; b++)
        begin
            if ((frame_q.dlc[3] == 1'b0) && (b >= int'(frame_q.dlc)))
            begin
                pay_masked[b*8 +: 8] = 8'h00;
            end
        end
    end

    // Word images, byte 0 in the lowest lane
    wire [31:0] word_lo   = pay_masked[31:0];
    wire [31:0] word_hi   = pay_masked[63:32];
    wire [15:0] stamp_fld = stamp_cap_q ? frame_q.stamp : 16'h0000;
    wire [31:0] word_sid  = {stamp_fld, frame_q.filter, frame_q.standard_identifier};
    wire [31:0] word_eid  = {2'b00, frame_q.srr, frame_q.ide, frame_q.eid,
                             frame_q.rtr, 1'b0, 3'b000, 1'b0, frame_q.dlc};

    // Word order: payload-only writes two words, full format four
    logic [31:0] word_now;
    always_comb
    begin
        if (pay_only_q)
        begin
            word_now = (word_q == 2'h0) ? word_lo : word_hi;
        end
        else
        begin
            case (word_q)
                2'h0:    word_now = word_sid;
                2'h1:    word_now = word_eid;
                2'h2:    word_now = word_lo;
                default: word_now = word_hi;
            endcase
        end
    end

    wire [1:0]  last_word = pay_only_q ? rx_store_pkg::LAST_WORD_PAY
                                       : rx_store_pkg::LAST_WORD_FULL;
    wire [31:0] wr_base_a = buf_addr(base_q, wr_idx_q, pay_only_q);
    wire [31:0] word_addr = wr_base_a + {28'h0, word_q, 2'b00};
    wire [31:0] user_addr = buf_addr(base_q, rd_idx_q, pay_sel);

    // Store sequencer
    always_comb
    begin
        case (state_q)
            rx_store_pkg::ST_IDLE:   state_d = take ? rx_store_pkg::ST_LOAD
                                                    : rx_store_pkg::ST_IDLE;
            rx_store_pkg::ST_LOAD:   state_d = rx_store_pkg::ST_WRITE;
            rx_store_pkg::ST_WRITE:
            begin
                if (mem_ack && (word_q == last_word))
                begin
                    state_d = rx_store_pkg::ST_COMMIT;
                end
                else if (mem_ack)
                begin
                    state_d = rx_store_pkg::ST_LOAD;
                end
                else
                begin
                    state_d = rx_store_pkg::ST_WRITE;
                end
            end
            rx_store_pkg::ST_COMMIT: state_d = rx_store_pkg::ST_IDLE;
            default:                 state_d = rx_store_pkg::ST_IDLE;
        endcase
    end

    // Unread count: store adds, bump removes
    always_comb
    begin
        count_d = count_q;
        if (wr_base)
        begin
            count_d = 4'h0;
        end
        else if (commit && !bump_ok)
        begin
            count_d = count_q + 4'h1;
        end
        else if (!commit && bump_ok)
        begin
            count_d = count_q - 4'h1;
        end
    end

    // Sticky events; a new event wins over a same-cycle clear
    logic [rx_store_pkg::FLAG_W-1:0] ev, clr;
    always_comb
    begin
        ev = '0;
        ev[rx_store_pkg::POS_NOT_EMPTY] = commit && (count_q == 4'h0);
        ev[rx_store_pkg::POS_HALF_FULL] = (count_d >= rx_store_pkg::HALF_LEVEL)
                                          && (count_q < rx_store_pkg::HALF_LEVEL);
        ev[rx_store_pkg::POS_FULL]      = (count_d == rx_store_pkg::DEPTH)
                                          && !lvl_full;
        ev[rx_store_pkg::POS_OVERFLOW]  = drop;
        clr = (apb_wr && hit_flag && pstrb[0]) ? pwdata[3:0] : 4'h0;
        flags_d = (flags_q & ~clr) | ev;
    end

    // Sequencer, frame latch and memory request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= rx_store_pkg::ST_IDLE;
            frame_q    <= '0;
            pay_only_q <= 1'b0;
            word_q     <= 2'h0;
            rx_ready_q <= 1'b0;
            mem_req_q  <= 1'b0;
            mem_word_q <= '0;
        end
        else
        begin
            state_q    <= state_d;
            rx_ready_q <= (state_d == rx_store_pkg::ST_IDLE) && !accept;
            if (take)
            begin
                frame_q    <= rx_frame;
                pay_only_q <= pay_sel;
                word_q     <= 2'h0;
            end
            if (state_q == rx_store_pkg::ST_LOAD)
            begin
                mem_req_q  <= 1'b1;
                mem_word_q <= '{addr: word_addr, wdata: word_now};
            end
            else if (mem_ack)
            begin
                mem_req_q  <= 1'b0;
                word_q     <= word_q + 2'h1;
            end
        end
    end

    // Ring pointers and unread count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_idx_q <= '0;
            rd_idx_q <= '0;
            count_q  <= 4'h0;
        end
        else
        begin
            count_q <= count_d;
            if (wr_base)
            begin
                wr_idx_q <= '0;
                rd_idx_q <= '0;
            end
            else
            begin
                if (commit)
                begin
                    wr_idx_q <= wr_idx_q + 3'h1;
                end
                if (bump_ok)
                begin
                    rd_idx_q <= rd_idx_q + 3'h1;
                end
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q      <= rx_store_pkg::RST_WORD;
            base_q      <= rx_store_pkg::RST_WORD;
            stamp_cap_q <= 1'b0;
            mask_q      <= rx_store_pkg::RST_FLAGS;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q <= {18'h0, 1'b0, ctrl_new[12], 12'h0};
            end
            if (wr_base)
            begin
                base_q <= {merge_strb(base_q, pwdata, pstrb)} & 32'hFFFF_FFFC;
            end
            if (apb_wr && hit_mod)
            begin
                stamp_cap_q <= mod_new[rx_store_pkg::POS_STAMP_CAP];
            end
            if (apb_wr && hit_mask)
            begin
                mask_q <= mask_new[3:0];
            end
        end
    end

    // Read data mux
    logic [31:0] rd_mux;
    always_comb
    begin
        case (1'b1)
            hit_ctrl: rd_mux = ctrl_q;
            hit_base: rd_mux = base_q;
            hit_ua:   rd_mux = user_addr;
            hit_wi:   rd_mux = {29'h0, wr_idx_q};
            hit_flag: rd_mux = {28'h0, flags_q};
            hit_mask: rd_mux = {28'h0, mask_q};
            hit_mod:  rd_mux = {31'h0, stamp_cap_q};
            hit_lvl:  rd_mux = {24'h0, count_q, 1'b0, lvl_full, lvl_half, lvl_ne};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // APB answer one cycle into the access phase; flags and irq
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            flags_q   <= rx_store_pkg::RST_FLAGS;
            irq_q     <= 1'b0;
        end
        else
        begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~hit_any;
            prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
            flags_q   <= flags_d;
            irq_q     <= |(flags_d & mask_q);
        end
    end

    // Outputs straight from flops
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign rx_ready = rx_ready_q;
    assign mem_req  = mem_req_q;
    assign mem_word = mem_word_q;
    assign irq      = irq_q;

endmodule // rx_msg_store

`default_nettype wire

// ==== src/rx_store_pkg.sv ====
/*
 * Constants and carrier types for the receive message store.
 * Assumes a 32-bit APB register bus and a 32-bit word-write memory port.
 */
`default_nettype none

package rx_store_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FIFO_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_BASE_ADDRESS  = 8'h04;
    localparam logic [7:0] OFS_USER_ADDRESS  = 8'h08;
    localparam logic [7:0] OFS_WRITE_INDEX   = 8'h0C;
    localparam logic [7:0] OFS_INT_FLAGS     = 8'h10;
    localparam logic [7:0] OFS_INT_MASK      = 8'h14;
    localparam logic [7:0] OFS_MODULE_CTRL   = 8'h18;
    localparam logic [7:0] OFS_LEVEL_STATUS  = 8'h1C;

    // Control field positions
    localparam int POS_PAYLOAD_ONLY = 12;
    localparam int POS_PTR_BUMP     = 13;
    localparam int POS_STAMP_CAP    = 0;

    // Flag positions in interrupt and level registers
    localparam int POS_NOT_EMPTY = 0;
    localparam int POS_HALF_FULL = 1;
    localparam int POS_FULL      = 2;
    localparam int POS_OVERFLOW  = 3;
    localparam int FLAG_W        = 4;

    // Ring geometry
    localparam int          IDX_W          = 3;
    localparam logic [3:0]  DEPTH          = 4'h8;
    localparam logic [3:0]  HALF_LEVEL     = 4'h4;
    localparam logic [31:0] STRIDE_FULL    = 32'h0000_0010;
    localparam logic [31:0] STRIDE_PAYLOAD = 32'h0000_0008;
    localparam logic [1:0]  LAST_WORD_FULL = 2'h3;
    localparam logic [1:0]  LAST_WORD_PAY  = 2'h1;

    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;

    // Received frame as handed over by the protocol receiver
    typedef struct packed {
        logic [15:0] stamp;
        logic [4:0]  filter;
        logic [10:0] standard_identifier;
        logic        srr;
        logic        ide;
        logic [17:0] eid;
        logic        rtr;
        logic [3:0]  dlc;
        logic [63:0] data;
    } rx_frame_t;

    // One word write towards system RAM
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_word_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_LOAD   = 4'b0010,
        ST_WRITE  = 4'b0100,
        ST_COMMIT = 4'b1000
    } store_state_t;

endpackage

`default_nettype wire

// ==== sim/rx_msg_store_sva.sv ====
/* Port checker for the receive message store: bus timing, frame handshake, RAM port.
   Assumes it is bound onto rx_msg_store and runs on its single clock. */
`default_nettype none

module rx_msg_store_sva (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // Register bus
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // Frames and RAM
    input wire logic                    rx_valid,
    input wire logic                    rx_ready,
    input wire logic                    mem_req,
    input wire rx_store_pkg::mem_word_t mem_word,
    input wire logic                    mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Register bus answer timing
    a_access_two_cyc: assert property (psel && penable && !pready |=> pready)
        else $error("no answer in second access cycle");
    a_answer_pulse: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without answer");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    // Frame handshake and store duration
    a_take_bounded: assert property (rx_valid && rx_ready |=> !rx_ready ##[1:300] rx_ready)
        else $error("store did not stall or never finished");
    a_idle_no_req: assert property (rx_ready |-> !mem_req)
        else $error("memory request while idle");
    // Plain word writes towards RAM
    a_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_word))
        else $error("memory request changed before ack");
    a_ack_ends_req: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request held after ack");
    a_word_aligned: assert property (mem_req |-> mem_word.addr[1:0] == 2'h0)
        else $error("unaligned memory word");
endmodule // rx_msg_store_sva

bind rx_msg_store rx_msg_store_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .mem_req(mem_req), .mem_word(mem_word), .mem_ack(mem_ack)
);

`default_nettype wire

// ==== sim/rx_ram_model.sv ====
/* System RAM model: word store with a settable stall before each ack.
   Assumes one word request held until its one-cycle ack. */
`default_nettype none

module rx_ram_model (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // Word write port
    input  wire logic                    mem_req,
    input  wire rx_store_pkg::mem_word_t mem_word,
    output logic                         mem_ack,
    // Stall cycles before each ack
    input  wire logic [3:0]              ack_wait
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255]; // Word store for addresses below 0x400
    logic [3:0]  wait_q;
    int          n_writes = 0;

    // Plain word store, no set/clear aliases; ack after the stall
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack <= 1'b0;
            wait_q <= 4'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            if (mem_req && mem_ack)
            begin
                mem[mem_word.addr[9:2]] <= mem_word.wdata;
                n_writes <= n_writes + 1;
                wait_q <= 4'h0;
            end
            else if (mem_req && wait_q >= ack_wait)
                mem_ack <= 1'b1;
            else if (mem_req)
                wait_q <= wait_q + 4'h1;
        end
    end
endmodule // rx_ram_model

`default_nettype wire

// ==== sim/can_receive_fifo_store_test.sv ====
/* Self-checking bench for the receive message store.
   Assumes the RAM model and the bound checker compile alongside. */
`default_nettype none

module can_receive_fifo_store_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_CTL = rx_store_pkg::OFS_FIFO_CONTROL;
    localparam logic [7:0] A_UA  = rx_store_pkg::OFS_USER_ADDRESS;
    localparam logic [7:0] A_WI  = rx_store_pkg::OFS_WRITE_INDEX;
    localparam logic [7:0] A_FL  = rx_store_pkg::OFS_INT_FLAGS;
    localparam logic [7:0] A_LV  = rx_store_pkg::OFS_LEVEL_STATUS;
    logic        pclk, presetn, psel, penable, pwrite, rx_valid, pready, pslverr;
    logic        rx_ready, mem_req, mem_ack, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, ack_wait;
    rx_store_pkg::rx_frame_t rx_frame;
    rx_store_pkg::mem_word_t mem_word;
    int          n_mismatch, n_tests;

    rx_msg_store dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
        .mem_req(mem_req), .mem_word(mem_word), .mem_ack(mem_ack), .irq(irq)
    );
    rx_ram_model u_ram (
        .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_word(mem_word),
        .mem_ack(mem_ack), .ack_wait(ack_wait)
    );

    // Free-running clock
    always #10 pclk = ~pclk;

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang(input int i);
        if (i >= 400)
        begin
            chk(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask

    // One bus transfer; read data and error taken at the answering edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 400)
        begin
            @(posedge pclk);
            i++;
        end
        hang(i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask

    // Offer one frame, then wait until the store is idle again
    task automatic send(input rx_store_pkg::rx_frame_t f);
        int i;
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_frame <= f;
        i = 0;
        @(negedge pclk);
        while (rx_ready !== 1'b1 && i < 400)
        begin
            @(negedge pclk);
            i++;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_frame <= ~f;
        @(negedge pclk);
        while (rx_ready !== 1'b1 && i < 400)
        begin
            @(negedge pclk);
            i++;
        end
        hang(i);
    endtask

    // Frame with distinct fields from a key
    function automatic rx_store_pkg::rx_frame_t mk(input logic [7:0] k, input logic [3:0] n);
        rx_store_pkg::rx_frame_t f;
        f.stamp = {8'hA5, k};
        f.filter = k[4:0] ^ 5'h15;
        f.standard_identifier = {3'h5, k};
        f.srr = 1'b1;
        f.ide = k[1];
        f.eid = {10'h2AB, k};
        f.rtr = k[0];
        f.dlc = n;
        f.data = {8{k}} ^ 64'h8776_6554_4332_2110;
        return f;
    endfunction

    // Expected payload words and stored message
    task automatic chk_msg(input rx_store_pkg::rx_frame_t f, input logic [31:0] a,
                           input logic pay, input logic cap);
        logic [63:0] d;
        logic [7:0]  i;
        i = a[9:2];
        d = 64'h0;
        for (int b = 0; b < 8; b++)
            if (b < f.dlc)
                d[8*b +: 8] = f.data[8*b +: 8];
        if (pay)
        begin
            chk(u_ram.mem[i], d[31:0]);
            chk(u_ram.mem[i + 8'h1], d[63:32]);
        end
        else
        begin
            chk(u_ram.mem[i], {cap ? f.stamp : 16'h0, f.filter, f.standard_identifier});
            chk(u_ram.mem[i + 8'h1], {2'h0, f.srr, f.ide, f.eid, f.rtr, 5'h0, f.dlc});
            chk(u_ram.mem[i + 8'h2], d[31:0]);
            chk(u_ram.mem[i + 8'h3], d[63:32]);
        end
    endtask

    // Reset values and an unmapped address
    task automatic s_regs();
        apb(1'b0, A_UA, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_LV, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
    endtask

    // Full format with and without time stamp
    task automatic s_full();
        apb(1'b1, rx_store_pkg::OFS_BASE_ADDRESS, 32'h100);
        apb(1'b1, rx_store_pkg::OFS_MODULE_CTRL, 32'h1);
        send(mk(8'h31, 4'h5));
        chk_msg(mk(8'h31, 4'h5), 32'h100, 1'b0, 1'b1);
        apb(1'b0, A_WI, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, A_UA, 32'h0);
        chk(rd, 32'h100);
        apb(1'b0, A_FL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, rx_store_pkg::OFS_MODULE_CTRL, 32'h0);
        send(mk(8'h52, 4'h9));
        chk_msg(mk(8'h52, 4'h9), 32'h110, 1'b0, 1'b0);
    endtask

    // Fill, overflow, interrupt, drain and wrap with a slow RAM
    task automatic s_ring();
        ack_wait <= 4'h3;
        apb(1'b1, rx_store_pkg::OFS_BASE_ADDRESS, 32'h200);
        apb(1'b1, A_FL, 32'hF);
        for (int k = 0; k < 8; k++)
        begin
            send(mk(8'(k), 4'h8));
            apb(1'b0, A_FL, 32'h0);
            chk(rd, {29'h0, k == 7, k >= 3, 1'b1});
        end
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, rx_store_pkg::OFS_INT_MASK, 32'h4);
        repeat (2) @(negedge pclk); // Interrupt follows a new mask one cycle later
        chk({31'h0, irq}, 32'h1);
        send(mk(8'hEE, 4'h8));
        apb(1'b0, A_WI, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_FL, 32'h0);
        chk(rd, 32'hF);
        chk_msg(mk(8'h0, 4'h8), 32'h200, 1'b0, 1'b0);
        apb(1'b1, A_FL, 32'hF);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        for (int k = 1; k <= 9; k++)
        begin
            apb(1'b1, A_CTL, 32'h2000);
            apb(1'b0, A_UA, 32'h0);
            chk(rd, 32'h200 + 32'(((k < 9) ? k % 8 : 0) * 16));
        end
    endtask

    // Payload-only storage and its stride
    task automatic s_pay();
        int w;
        ack_wait <= 4'h0;
        apb(1'b1, A_CTL, 32'h1000);
        apb(1'b1, rx_store_pkg::OFS_BASE_ADDRESS, 32'h300);
        apb(1'b1, rx_store_pkg::OFS_MODULE_CTRL, 32'h1);
        w = u_ram.n_writes;
        send(mk(8'h93, 4'h3));
        chk(32'(u_ram.n_writes - w), 32'h2);
        chk_msg(mk(8'h93, 4'h3), 32'h300, 1'b1, 1'b1);
        send(mk(8'hA4, 4'h8));
        chk_msg(mk(8'hA4, 4'h8), 32'h308, 1'b1, 1'b1);
        apb(1'b1, A_CTL, 32'h3000);
        apb(1'b0, A_UA, 32'h0);
        chk(rd, 32'h308);
    endtask

    // Main sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, rx_valid} = 4'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        ack_wait = 4'h1;
        rx_frame = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_full();
        s_ring();
        s_pay();
        tally_and_finish();
    end
endmodule // can_receive_fifo_store_test

`default_nettype wire
